/* File: spfr_ahb_port.sv */
// AHB-Lite slave front end: splits transfers into read and write strokes
// assumes single word transfers, one slave, zero wait states
`timescale 1ns/1ps
`default_nettype none
module spfr_ahb_port (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    output logic rd_req_o,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    import spfr_pkg::*;

    logic take;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic rdy_ff;

    // ----------------------------------------------------------------
    // address phase
    // ----------------------------------------------------------------
    assign take = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
    assign rd_req_o = take & ~hwrite_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else if (ce_i) begin
            wr_pend_ff <= take & hwrite_i;
            if (take & hwrite_i) begin
                wr_addr_ff <= haddr_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // data phase: ready from the first enabled clock after reset, always okay
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdy_ff <= 1'b0;
        end else if (ce_i) begin
            rdy_ff <= 1'b1;
        end
    end

    assign wr_en_o = wr_pend_ff & ce_i;
    assign wr_addr_o = wr_addr_ff;
    assign hreadyout_o = rdy_ff;
    assign hresp_o = 1'b0;
endmodule
`default_nettype wire

/* File: spfr_pin_model.sv */
// reset pin model: pull-up line, optional external low drive
// assumes the block's split pin: value, active-low enable, readback
`timescale 1ns/1ps
`default_nettype none
module spfr_pin_model (
    input wire logic out_i,
    input wire logic oe_n_i,
    input wire logic ext_low_i,
    output logic pin_o
);
    // pull-up holds the line high when nobody drives it
    assign pin_o = !oe_n_i ? out_i : !ext_low_i;
endmodule
`default_nettype wire

/* File: spfr_pkg.sv */
// constants shared by the supply monitor / power-fail reset block
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
package spfr_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned REL_DELAY_NS = 400;
    localparam int unsigned REL_DELAY_RAW =
        (REL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REL_DELAY_CYC =
        (REL_DELAY_RAW < 1) ? 1 : REL_DELAY_RAW;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RSRC = 8'h04;
    localparam logic [7:0] OFF_IRQ_ST = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_STAT_BIT = 6;
    localparam int unsigned RSRC_SEL_BIT = 1;
    localparam int unsigned RSRC_FERR_BIT = 6;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_PFAIL_BIT = 0;
    localparam int unsigned IRQ_FERR_BIT = 1;
    localparam int unsigned IRQ_RECOV_BIT = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic MON_EN_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b1;
    localparam logic MON_SEL_RST = 1'b0;
    localparam logic FERR_FLAG_RST = 1'b0;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_PFAIL,
        ST_HOLD
    } spfr_state_t;

endpackage

/* File: spfr_props.sv */
// port checks for the supply monitor block
// assumes binding onto spfr_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module spfr_props
import spfr_pkg::*;
#(parameter int unsigned REL_CYC = 4) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic SUPPLY_OK_I,
    input wire logic FLASH_REQ_I,
    input wire logic FLASH_GO_O,
    input wire logic RST_PIN_IN_I,
    input wire logic RST_PIN_OE_N_O,
    input wire logic CORE_RST_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);
    logic [15:0] cnt_ff;
    // ----
    // cycles held in reset with supply good
    // ----
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_ff <= 16'h0000;
        end else if (CORE_RST_O && SUPPLY_OK_I && CE_I &&
                     (RST_PIN_IN_I || !RST_PIN_OE_N_O)) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end else begin
            cnt_ff <= 16'h0000;
        end
    end
    property p_pin_core;
        !RST_PIN_OE_N_O |-> CORE_RST_O;
    endproperty
    a_pin_core: assert property (p_pin_core)
        else $error("pin driven but core free");
    property p_fail_cause;
        $fell(RST_PIN_OE_N_O) |-> !$past(SUPPLY_OK_I);
    endproperty
    a_fail_cause: assert property (p_fail_cause)
        else $error("pin driven without low supply");
    property p_rel_bound;
        cnt_ff <= REL_CYC + 2;
    endproperty
    a_rel_bound: assert property (p_rel_bound)
        else $error("core held too long");
    property p_rel_pin;
        $fell(CORE_RST_O) |-> RST_PIN_OE_N_O;
    endproperty
    a_rel_pin: assert property (p_rel_pin)
        else $error("core freed with pin driven");
    property p_go_cause;
        FLASH_GO_O |-> $past(FLASH_REQ_I) && !$past(CORE_RST_O);
    endproperty
    a_go_cause: assert property (p_go_cause)
        else $error("flash go without request");
    property p_flash_ans;
        CE_I && FLASH_REQ_I && !CORE_RST_O |=> FLASH_GO_O || CORE_RST_O;
    endproperty
    a_flash_ans: assert property (p_flash_ans)
        else $error("flash request unanswered");
    property p_quiet;
        $rose(CORE_RST_O) && RST_PIN_OE_N_O
            |-> $past(FLASH_REQ_I) || !$past(RST_PIN_IN_I);
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("silent reset without cause");
    property p_stat_rd;
        HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I && CE_I &&
            HSIZE_I == HSIZE_WORD && HADDR_I[7:0] == OFF_CTRL
            |=> HRDATA_O[6] == $past(SUPPLY_OK_I) && HRDATA_O[5:0] == 6'h00;
    endproperty
    a_stat_rd: assert property (p_stat_rd)
        else $error("control read wrong");
    property p_okay;
        HRESP_O == 1'b0 and (HREADYOUT_O |=> HREADYOUT_O);
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response wrong");
endmodule
bind spfr_top spfr_props #(.REL_CYC(REL_CYC)) i_spfr_props (.MCLK_I,
    .RST_N_I, .CE_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I,
    .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O, .SUPPLY_OK_I,
    .FLASH_REQ_I, .FLASH_GO_O, .RST_PIN_IN_I, .RST_PIN_OE_N_O, .CORE_RST_O);
`default_nettype wire

/* File: spfr_top.sv */
// supply monitor and power-fail reset controller with its registers
// assumes the comparator output and flash requests are clock-synchronous
//
// Behaviour
// - supply low drives pin, holds core reset
// - supply recovered releases core from reset
// - power-fail reset leaves data memory untouched
// - power-on enables monitor; other resets keep
// - flash op with monitor off: error reset
// - power-on exit sets flag bit 1
// - flash error reset sets flag bit 6
`timescale 1ns/1ps
`default_nettype none
module spfr_top #(
    parameter int unsigned REL_CYC = spfr_pkg::REL_DELAY_CYC,
    parameter int unsigned CNT_W = 8
) (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SUPPLY_OK_I,
    input wire logic FLASH_REQ_I,
    output logic FLASH_GO_O,
    input wire logic RST_PIN_IN_I,
    output logic RST_PIN_OUT_O,
    output logic RST_PIN_OE_N_O,
    output logic CORE_RST_O,
    output logic IRQ_O
);
    import spfr_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (REL_CYC < 1 || REL_CYC >= (1 << CNT_W)) begin : g_chk
        $error("release delay does not fit the counter");
    end

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rd_req;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] rdata_ff;
    logic mon_en_ff;
    logic mon_sel_ff;
    logic por_flag_ff;
    logic ferr_flag_ff;
    logic [IRQ_W-1:0] irq_st_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic irq_ff;
    spfr_state_t state_ff;
    spfr_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic drive_ff;
    logic nxt_drive;
    logic core_rst_ff;
    logic flash_go_ff;
    logic pfail_cond;
    logic ext_rst;
    logic ferr_evt;
    logic pfail_evt;
    logic recov_evt;
    logic [IRQ_W-1:0] irq_evt;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [CNT_W-1:0] rel_count();
        rel_count = CNT_W'(REL_CYC - 1);
    endfunction

    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    spfr_ahb_port i_spfr_ahb_port (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I[7:0]),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hready_i(HREADY_I),
        .rd_req_o(rd_req),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O)
    );

    // ----------------------------------------------------------------
    // reset causes
    // ----------------------------------------------------------------
    assign pfail_cond = mon_en_ff & mon_sel_ff & ~SUPPLY_OK_I;
    assign ext_rst = ~RST_PIN_IN_I & ~drive_ff;
    // flash op refused while the monitor is off
    assign ferr_evt = (state_ff == ST_RUN) & FLASH_REQ_I & ~mon_en_ff;
    assign pfail_evt = (state_ff != ST_PFAIL) & (nxt_state == ST_PFAIL);
    assign recov_evt = (state_ff == ST_PFAIL) & (nxt_state != ST_PFAIL);

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_drive = drive_ff;
        case (state_ff)
            ST_RUN: begin
                if (pfail_cond) begin
                    nxt_state = ST_PFAIL;
                    nxt_drive = 1'b1;
                end else if (ferr_evt || ext_rst) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = rel_count();
                    nxt_drive = 1'b0;
                end
            end
            ST_PFAIL: begin
                if (SUPPLY_OK_I) begin
                    nxt_state = ST_HOLD;
                    nxt_cnt = rel_count();
                end
            end
            ST_HOLD: begin
                if (pfail_cond) begin
                    nxt_state = ST_PFAIL;
                    nxt_drive = 1'b1;
                end else if (ext_rst) begin
                    nxt_cnt = rel_count();
                end else if (cnt_ff == '0) begin
                    nxt_state = ST_RUN;
                    nxt_drive = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end
            default: begin
                nxt_state = ST_HOLD;
                nxt_cnt = rel_count();
                nxt_drive = 1'b1;
            end
        endcase
    end

    // power-on starts in hold with the pin driven low
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= ST_HOLD;
            cnt_ff <= CNT_W'(REL_CYC - 1);
            drive_ff <= 1'b1;
        end else if (CE_I) begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            drive_ff <= nxt_drive;
        end
    end

    // core reset only; no memory wipe is ever issued
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            core_rst_ff <= 1'b1;
        end else if (CE_I) begin
            core_rst_ff <= (nxt_state != ST_RUN);
        end
    end

    // flash pass-through only while running with the monitor on
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flash_go_ff <= 1'b0;
        end else if (CE_I) begin
            flash_go_ff <= (state_ff == ST_RUN) & FLASH_REQ_I & mon_en_ff
                & ~pfail_cond;
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // only the power-on reset touches the enable
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mon_en_ff <= MON_EN_RST;
        end else if (CE_I) begin
            if (wr_en && hit(wr_addr, OFF_CTRL)) begin
                mon_en_ff <= HWDATA_I[CTRL_EN_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // reset-source register
    // ----------------------------------------------------------------
    // select is lost on flash/external resets, kept on power fail
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mon_sel_ff <= MON_SEL_RST;
        end else if (CE_I) begin
            if (state_ff == ST_RUN && (ferr_evt || ext_rst) && !pfail_cond) begin
                mon_sel_ff <= 1'b0;
            end else if (wr_en && hit(wr_addr, OFF_RSRC)) begin
                mon_sel_ff <= HWDATA_I[RSRC_SEL_BIT];
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            por_flag_ff <= POR_FLAG_RST;
            ferr_flag_ff <= FERR_FLAG_RST;
        end else if (CE_I) begin
            if (pfail_evt) begin
                por_flag_ff <= 1'b1;
                ferr_flag_ff <= 1'b0;
            end else if (state_ff == ST_RUN && ferr_evt) begin
                por_flag_ff <= 1'b0;
                ferr_flag_ff <= 1'b1;
            end else if (state_ff == ST_RUN && ext_rst) begin
                por_flag_ff <= 1'b0;
                ferr_flag_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable and clear
    // ----------------------------------------------------------------
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_PFAIL_BIT] = pfail_evt;
        irq_evt[IRQ_FERR_BIT] = ferr_evt;
        irq_evt[IRQ_RECOV_BIT] = recov_evt;
    end

    // a new event wins over a clear in the same cycle
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_st_ff <= '0;
        end else if (CE_I) begin
            if (wr_en && hit(wr_addr, OFF_IRQ_CLR)) begin
                irq_st_ff <= (irq_st_ff & ~HWDATA_I[IRQ_W-1:0]) | irq_evt;
            end else begin
                irq_st_ff <= irq_st_ff | irq_evt;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_en_ff <= IRQ_EN_RST;
        end else if (CE_I) begin
            if (wr_en && hit(wr_addr, OFF_IRQ_EN)) begin
                irq_en_ff <= HWDATA_I[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_ff <= 1'b0;
        end else if (CE_I) begin
            irq_ff <= |(irq_st_ff & irq_en_ff);
        end
    end

    // ----------------------------------------------------------------
    // read data, loaded in the address phase
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_ff <= RDATA_RST;
        end else if (CE_I && rd_req) begin
            rdata_ff <= RDATA_RST;
            if (hit(HADDR_I[7:0], OFF_CTRL)) begin
                rdata_ff[CTRL_EN_BIT] <= mon_en_ff;
                rdata_ff[CTRL_STAT_BIT] <= SUPPLY_OK_I;
            end else if (hit(HADDR_I[7:0], OFF_RSRC)) begin
                rdata_ff[RSRC_SEL_BIT] <= por_flag_ff;
                rdata_ff[RSRC_FERR_BIT] <= ferr_flag_ff;
            end else if (hit(HADDR_I[7:0], OFF_IRQ_ST)) begin
                rdata_ff[IRQ_W-1:0] <= irq_st_ff;
            end else if (hit(HADDR_I[7:0], OFF_IRQ_EN)) begin
                rdata_ff[IRQ_W-1:0] <= irq_en_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign HRDATA_O = rdata_ff;
    assign CORE_RST_O = core_rst_ff;
    assign RST_PIN_OUT_O = 1'b0;
    assign RST_PIN_OE_N_O = ~drive_ff;
    assign FLASH_GO_O = flash_go_ff;
    assign IRQ_O = irq_ff;
endmodule
`default_nettype wire

/* File: tb_spfr_top.sv */
// bench for the supply monitor block over its register bus
// assumes spfr_top, spfr_pin_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_spfr_top;
import spfr_pkg::*;
localparam int unsigned REL = 3;
logic MCLK_I, RST_N_I, CE_I, HSEL_I, HWRITE_I, HREADYOUT_O, HRESP_O;
logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd_q;
logic [1:0] HTRANS_I;
logic [2:0] HSIZE_I;
logic SUPPLY_OK_I, FLASH_REQ_I, FLASH_GO_O, RST_PIN_IN_I, ext_low;
logic RST_PIN_OUT_O, RST_PIN_OE_N_O, CORE_RST_O, IRQ_O;
logic [2:0] mon;
int error_cnt, samples_checked;
assign mon = {IRQ_O, RST_PIN_OE_N_O, CORE_RST_O};
spfr_top #(.REL_CYC(REL)) i_spfr_top (.MCLK_I, .RST_N_I, .CE_I,
    .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I,
    .HREADY_I(HREADYOUT_O), .HRDATA_O, .HREADYOUT_O, .HRESP_O,
    .SUPPLY_OK_I, .FLASH_REQ_I, .FLASH_GO_O, .RST_PIN_IN_I,
    .RST_PIN_OUT_O, .RST_PIN_OE_N_O, .CORE_RST_O, .IRQ_O);
spfr_pin_model i_spfr_pin_model (.out_i(RST_PIN_OUT_O),
    .oe_n_i(RST_PIN_OE_N_O), .ext_low_i(ext_low), .pin_o(RST_PIN_IN_I));
initial begin
    MCLK_I = 1'b0;
    forever #50 MCLK_I = ~MCLK_I;
end
// ----
// helpers
// ----
task stop_test;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask
task tmo;
    $display("ERROR t=%0t timeout", $time);
    error_cnt++;
    stop_test();
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        error_cnt++;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
endtask
task wait_bit(input int b, input logic v);
    int n;
    n = 0;
    @(negedge MCLK_I);
    while (mon[b] !== v) begin
        n++;
        if (n > 60) tmo();
        @(negedge MCLK_I);
    end
endtask
task rdy;
    int n;
    n = 0;
    @(negedge MCLK_I);
    while (HREADYOUT_O !== 1'b1) begin
        n++;
        if (n > 16) tmo();
        @(negedge MCLK_I);
    end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'b10;
    HADDR_I <= {24'h00_0000, a};
    HWRITE_I <= w;
    rdy();
    @(posedge MCLK_I);
    HTRANS_I <= 2'b00;
    HWDATA_I <= d;
    rdy();
    rd_q = HRDATA_O;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    @(posedge MCLK_I);
endtask
task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd_q, exp);
endtask
task flash(input logic go);
    int n;
    n = 0;
    @(posedge MCLK_I);
    FLASH_REQ_I <= 1'b1;
    @(posedge MCLK_I);
    FLASH_REQ_I <= 1'b0;
    repeat (3) begin
        @(negedge MCLK_I);
        if (FLASH_GO_O === 1'b1) n++;
    end
    chk(32'(n), 32'(go));
endtask
task por;
    @(posedge MCLK_I);
    RST_N_I <= 1'b0;
    repeat (2) @(posedge MCLK_I);
    RST_N_I <= 1'b1;
    wait_bit(0, 1'b0);
endtask
// ----
// main sequence
// ----
initial begin
    error_cnt = 0;
    samples_checked = 0;
    RST_N_I = 1'b0;
    CE_I = 1'b1;
    HSEL_I = 1'b0;
    HADDR_I = 32'h0000_0000;
    HTRANS_I = 2'b00;
    HWRITE_I = 1'b0;
    HSIZE_I = HSIZE_WORD;
    HWDATA_I = 32'h0000_0000;
    SUPPLY_OK_I = 1'b1;
    FLASH_REQ_I = 1'b0;
    ext_low = 1'b0;
    por();
    rd(OFF_CTRL, 32'h0000_00C0);
    rd(OFF_RSRC, 32'h0000_0002);
    rd(OFF_IRQ_EN, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    $display("reset values test done");
    repeat (50) @(posedge MCLK_I);
    wr(OFF_RSRC, 32'h0000_0002);
    wr(OFF_IRQ_EN, 32'h0000_0007);
    @(posedge MCLK_I);
    SUPPLY_OK_I <= 1'b0;
    wait_bit(1, 1'b0);
    chk(32'({CORE_RST_O, RST_PIN_IN_I}), 32'h0000_0002);
    rd(OFF_CTRL, 32'h0000_0080);
    rd(OFF_IRQ_ST, 32'h0000_0001);
    wait_bit(2, 1'b1);
    @(posedge MCLK_I);
    SUPPLY_OK_I <= 1'b1;
    wait_bit(0, 1'b0);
    chk(32'(RST_PIN_OE_N_O), 32'h0000_0001);
    rd(OFF_RSRC, 32'h0000_0002);
    rd(OFF_IRQ_ST, 32'h0000_0005);
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    rd(OFF_IRQ_ST, 32'h0000_0000);
    wait_bit(2, 1'b0);
    $display("power fail test done");
    flash(1'b1);
    wr(OFF_CTRL, 32'h0000_0000);
    rd(OFF_CTRL, 32'h0000_0040);
    flash(1'b0);
    chk(32'({CORE_RST_O, RST_PIN_OE_N_O}), 32'h0000_0003);
    wait_bit(0, 1'b0);
    rd(OFF_RSRC, 32'h0000_0040);
    rd(OFF_CTRL, 32'h0000_0040);
    rd(OFF_IRQ_ST, 32'h0000_0002);
    wait_bit(2, 1'b1);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    wait_bit(2, 1'b0);
    wr(OFF_IRQ_CLR, 32'h0000_0007);
    $display("flash test done");
    @(posedge MCLK_I);
    ext_low <= 1'b1;
    wait_bit(0, 1'b1);
    @(posedge MCLK_I);
    ext_low <= 1'b0;
    wait_bit(0, 1'b0);
    rd(OFF_CTRL, 32'h0000_0040);
    por();
    rd(OFF_CTRL, 32'h0000_00C0);
    rd(OFF_RSRC, 32'h0000_0002);
    $display("reset kinds test done");
    @(posedge MCLK_I);
    CE_I <= 1'b0;
    flash(1'b0);
    chk(32'(CORE_RST_O), 32'h0000_0000);
    @(posedge MCLK_I);
    CE_I <= 1'b1;
    flash(1'b1);
    $display("clock enable test done");
    stop_test();
end
endmodule
`default_nettype wire
